// >>> rtl/service_request_ack_chain.sv
// service request posting, acknowledge, context switch and daisy chain
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "svc_chain_defs.svh"

// Function
// RULE_01: host acks with matching acknowledge read
// RULE_02: host decodes returned vector byte
// RULE_03: host reads channel indicator during service
// RULE_04: any end-of-service write ends hardware service
// RULE_05: summary low bits invert request outputs
// RULE_06: host polls summary for set bits
// RULE_07: pending request loads its context register
// RULE_08: context copy to access register switches context
// RULE_09: context holds channel, code, status fields
// RULE_10: unique middle code selects ending type
// RULE_11: write-back with top bits clear ends poll
// RULE_12: host waits for switch before channel access
// RULE_13: chain arbitration only with hardware acknowledge
// RULE_14: open-drain requests, shared line monitored
// RULE_15: post only while fair bit inactive
// RULE_16: host ORs acks into first grant
// RULE_17: granted ack with pending request is claimed
// RULE_18: unclaimed grant passes to next device
// RULE_19: host writes unique chip id
// RULE_20: host aborts unclaimed acknowledge cycles
// RULE_21: vector gets base upper bits on post
// RULE_22: type codes 001, 010, 011, 111
// RULE_23: ack selected without chip select; end returns
// RULE_24: pass only while granted and unclaimed
module service_request_ack_chain
    import svc_chain_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire chan_req_t [2:0] chan_req,
    output svc_t svc,
    input wire logic rx_request_n_in,
    output logic rx_request_n_out,
    output logic rx_request_n_oe,
    input wire logic tx_request_n_in,
    output logic tx_request_n_out,
    output logic tx_request_n_oe,
    input wire logic line_change_request_n_in,
    output logic line_change_request_n_out,
    output logic line_change_request_n_oe,
    input wire logic rx_acknowledge_n,
    input wire logic tx_acknowledge_n,
    input wire logic line_change_acknowledge_n,
    input wire logic chain_grant_in_n,
    output logic chain_pass_out_n,
    output logic [7:0] ack_data_out,
    output logic ack_data_oe
);

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    // register index, 4'hF for unmapped
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        case (a)
            `OFS_SUMMARY: reg_index = 4'h0;
            `OFS_RX_CTX: reg_index = 4'h1;
            `OFS_TX_CTX: reg_index = 4'h2;
            `OFS_LC_CTX: reg_index = 4'h3;
            `OFS_CAR: reg_index = 4'h4;
            `OFS_EOS: reg_index = 4'h5;
            `OFS_LOCAL_VECTOR_BASE: reg_index = 4'h6;
            `OFS_RX_VEC: reg_index = 4'h7;
            `OFS_TX_VEC: reg_index = 4'h8;
            `OFS_LC_VEC: reg_index = 4'h9;
            `OFS_RX_IND: reg_index = 4'hA;
            `OFS_TX_IND: reg_index = 4'hB;
            `OFS_LC_IND: reg_index = 4'hC;
            default: reg_index = 4'hF;
        endcase
    endfunction

    function automatic logic [2:0] ctx_code(input logic [1:0] t);
        case (t)
            2'h0: ctx_code = `CTX_CODE_RX;
            2'h1: ctx_code = `CTX_CODE_TX;
            default: ctx_code = `CTX_CODE_LC;
        endcase
    endfunction

    function automatic logic [2:0] vec_code(input logic [1:0] t, input logic exc);
        case (t)
            2'h0: vec_code = exc ? `VEC_CODE_RX_EXC : `VEC_CODE_RX_GOOD;
            2'h1: vec_code = `VEC_CODE_TX;
            default: vec_code = `VEC_CODE_LC;
        endcase
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    ctrl_state_t st;
    ctrl_state_t next_st;
    logic [6:0] pins;
    logic [2:0] line_low;
    logic [2:0] ack;
    logic grant;
    logic any_ack;
    logic [1:0] ack_kind;
    logic wr;
    logic setup;
    logic [3:0] widx;
    logic [1:0] car_hit_kind;
    logic car_hit;

    // sync bits: [2:0] shared request lines, [5:3] acks, [6] grant, all inverted to active high
    assign pins = {~chain_grant_in_n, ~line_change_acknowledge_n, ~tx_acknowledge_n,
                   ~rx_acknowledge_n, ~line_change_request_n_in, ~tx_request_n_in,
                   ~rx_request_n_in};
    assign line_low = st.filt[2:0];
    assign ack = st.filt[5:3];
    assign grant = st.filt[6];
    assign any_ack = |ack;
    assign ack_kind = ack[0] ? 2'h0 : (ack[1] ? 2'h1 : 2'h2);
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite;
    assign widx = reg_index(paddr);

    // access register hit: value matches an active context
    always_comb begin
        car_hit = 1'b0;
        car_hit_kind = 2'h0;
        for (int t = 2; t >= 0; t--) begin
            if (st.ctx[t][`CTX_ACTIVE_BIT] && pwdata[7:0] == st.ctx[t]) begin
                car_hit = 1'b1;
                car_hit_kind = 2'(t);
            end
        end
    end

    always_comb begin
        next_st = st;
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        for (int i = 0; i < 7; i++) begin
            if (st.sync2[i] == st.sync3[i]) begin
                next_st.filt[i] = st.sync3[i];
            end
        end

        // ****************************************************************
        // posting
        // ****************************************************************
        for (int t = 0; t < 3; t++) begin
            // wired line high again: other devices had their turn
            if (st.fair[t] && !line_low[t] && !st.posted[t]) begin
                next_st.fair[t] = 1'b0; // see RULE_14
            end
            if (chan_req[t].valid && !st.posted[t] && !st.fair[t]
                && !st.ctx[t][`CTX_ACTIVE_BIT]) begin // see RULE_15
                next_st.posted[t] = 1'b1;
                next_st.ctx[t] = {1'b1, 1'b0, 1'b0, ctx_code(2'(t)),
                                  chan_req[t].channel}; // see RULE_07 RULE_09 RULE_10
                next_st.vec[t] = {st.local_vector_base[7:3],
                                  vec_code(2'(t), chan_req[t].exception)}; // see RULE_21 RULE_22
            end
        end

        // ****************************************************************
        // hardware acknowledge and chain
        // ****************************************************************
        // chip select plays no part here; ack and grant alone select
        if (any_ack && grant && st.posted[ack_kind] && st.mode == SVC_IDLE
            && !st.claimed) begin // see RULE_17 RULE_23
            next_st.claimed = 1'b1;
            next_st.mode = SVC_HW;
            next_st.cur = ack_kind;
            next_st.posted[ack_kind] = 1'b0;
            next_st.ctx[ack_kind][`CTX_SERVICE_BIT] = 1'b1;
        end
        if (!any_ack) begin
            next_st.claimed = 1'b0;
        end
        // pass decision only for granted acks we cannot claim
        next_st.pass_n = !(any_ack && grant && !st.claimed
                           && !st.posted[ack_kind]); // see RULE_18 RULE_24 RULE_13

        // ****************************************************************
        // register bus
        // ****************************************************************
        if (wr) begin
            case (widx)
                4'h1, 4'h2, 4'h3: begin
                    // polled end: our own value back with upper two bits cleared
                    if (st.mode == SVC_POLL && st.cur == 2'(widx - 4'h1)
                        && pwdata[7:6] == 2'b00
                        && pwdata[5:0] == st.ctx[st.cur][5:0]) begin // see RULE_11
                        next_st.mode = SVC_IDLE;
                        next_st.ctx[st.cur] = `BYTE_ZERO;
                        next_st.fair[st.cur] = 1'b1;
                    end
                end
                4'h4: begin
                    // register path leaves the chain untouched
                    if (st.mode == SVC_IDLE && car_hit) begin // see RULE_08 RULE_13
                        next_st.mode = SVC_POLL;
                        next_st.cur = car_hit_kind;
                        next_st.posted[car_hit_kind] = 1'b0;
                        next_st.ctx[car_hit_kind][`CTX_SERVICE_BIT] = 1'b1;
                    end
                end
                4'h5: begin
                    // data ignored; ctx code names the type that ends
                    if (st.mode == SVC_HW) begin // see RULE_04 RULE_10 RULE_23
                        for (int t = 0; t < 3; t++) begin
                            if (st.ctx[t][4:2] == ctx_code(st.cur)) begin
                                next_st.ctx[t] = `BYTE_ZERO;
                                next_st.fair[t] = 1'b1;
                            end
                        end
                        next_st.mode = SVC_IDLE;
                    end
                end
                4'h6: next_st.local_vector_base = {pwdata[7:3], 3'b000};
                default: ;
            endcase
        end

        // read data captured in setup so it comes from a flop
        next_st.err = setup & (widx == 4'hF);
        if (setup) begin
            next_st.rdata = `WORD_ZERO;
            case (widx)
                4'h0: next_st.rdata[2:0] = st.posted; // see RULE_05
                4'h1, 4'h2, 4'h3: next_st.rdata[7:0] = st.ctx[2'(widx - 4'h1)];
                4'h6: next_st.rdata[7:0] = st.local_vector_base;
                4'h7, 4'h8, 4'h9: next_st.rdata[7:0] = st.vec[2'(widx - 4'h7)];
                4'hA, 4'hB, 4'hC: next_st.rdata[1:0] = st.ctx[2'(widx - 4'hA)][1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{sync1: 7'h00, sync2: 7'h00, sync3: 7'h00, filt: 7'h00,
                    posted: 3'h0, fair: 3'h0, ctx: '0, vec: '0, local_vector_base: `LOCAL_VECTOR_BASE_RESET,
                    mode: SVC_IDLE, cur: 2'h0, claimed: 1'b0, pass_n: 1'b1,
                    rdata: `WORD_ZERO, err: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = st.err;
    // open drain: only ever pull low
    assign rx_request_n_out = 1'b0; // see RULE_14
    assign tx_request_n_out = 1'b0;
    assign line_change_request_n_out = 1'b0;
    assign rx_request_n_oe = st.posted[0];
    assign tx_request_n_oe = st.posted[1];
    assign line_change_request_n_oe = st.posted[2];
    assign chain_pass_out_n = st.pass_n;
    assign ack_data_out = st.vec[st.cur];
    assign ack_data_oe = st.claimed & any_ack; // see RULE_17
    assign svc = '{active: st.mode != SVC_IDLE, hw: st.mode == SVC_HW, kind: st.cur,
                   channel: st.ctx[st.cur][1:0]};

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_summary_mirror: assert property ( // see RULE_05
        setup && paddr == `OFS_SUMMARY |=> prdata[2:0] ==
            $past({line_change_request_n_oe, tx_request_n_oe, rx_request_n_oe}))
        else $error("summary does not mirror request outputs");
    a_request_open_drain: assert property ( // see RULE_14
        {rx_request_n_out, tx_request_n_out, line_change_request_n_out} == 3'b000)
        else $error("request output driven high");
    a_fair_blocks_post: assert property ( // see RULE_15
        $rose(st.posted[1]) |-> !$past(st.fair[1]))
        else $error("request posted while fair bit set");
    a_tx_vector_load: assert property ( // see RULE_21
        $rose(st.posted[1]) |-> st.vec[1] == {$past(st.local_vector_base[7:3]), 3'b010})
        else $error("transmit vector wrong after post");
    a_rx_ctx_layout: assert property ( // see RULE_09
        $rose(st.posted[0]) |-> st.ctx[0][4:2] == `CTX_CODE_RX && st.ctx[0][7])
        else $error("receive context layout wrong");
    a_claim_vector: assert property ( // see RULE_17
        ack_data_oe |-> st.cur == ack_kind && ack_data_out[2:0] != 3'b000 && st.mode == SVC_HW)
        else $error("claimed ack without vector");
    a_pass_granted: assert property ( // see RULE_24
        !chain_pass_out_n |-> $past(grant) && $past(any_ack) && !ack_data_oe)
        else $error("pass out without grant or while claiming");
    a_eos_ends_hw: assert property ( // see RULE_04
        wr && paddr == `OFS_EOS && st.mode == SVC_HW |=> st.mode == SVC_IDLE ##1 !svc.active)
        else $error("end of service did not end context");
    a_car_switch: assert property ( // see RULE_08
        wr && paddr == `OFS_CAR && st.mode == SVC_IDLE && car_hit
        |=> st.mode == SVC_POLL && svc.active && !svc.hw)
        else $error("access register copy did not switch");
    a_poll_end: assert property ( // see RULE_11
        st.mode == SVC_POLL && wr && paddr == `OFS_TX_CTX && st.cur == 2'h1
        && pwdata[7:0] == {2'b00, st.ctx[1][5:0]} |=> st.mode == SVC_IDLE && st.fair[1])
        else $error("poll write-back did not end service");

    // vector code, chain and service end checks
    a_rx_vector_code: assert property ( // see RULE_22
        $rose(st.posted[0]) |-> st.vec[0][2:0] ==
            ($past(chan_req[0].exception) ? `VEC_CODE_RX_EXC : `VEC_CODE_RX_GOOD))
        else $error("receive vector code wrong after post");
    a_claim_takes_req: assert property ( // see RULE_17
        $rose(st.claimed) |-> !st.posted[st.cur] && $past(grant) && st.mode == SVC_HW)
        else $error("claim without grant or request kept");
    a_unclaimed_pass: assert property ( // see RULE_18
        any_ack && grant && !st.claimed && !st.posted[ack_kind]
        |=> !chain_pass_out_n && !ack_data_oe)
        else $error("unclaimed grant not passed on");
    a_pass_release: assert property ( // see RULE_24
        !any_ack |=> chain_pass_out_n)
        else $error("pass held after acknowledge ended");
    a_poll_keeps_eos: assert property ( // see RULE_10
        wr && paddr == `OFS_EOS && st.mode == SVC_POLL |=> st.mode == SVC_POLL)
        else $error("end of service write acted in poll mode");
    a_eos_sets_fair: assert property ( // see RULE_15
        wr && paddr == `OFS_EOS && st.mode == SVC_HW && st.cur == 2'h0 |=> st.fair[0])
        else $error("fair bit not set at service end");

    c_hw_service: cover property (ack_data_oe ##[1:50] (wr && paddr == `OFS_EOS));
    c_poll_service: cover property (st.mode == SVC_POLL ##[1:50] st.mode == SVC_IDLE);
    c_chain_pass: cover property (!chain_pass_out_n);
    c_car_switch: cover property (wr && paddr == `OFS_CAR && car_hit);
    c_exc_vector: cover property (st.vec[0][2:0] == `VEC_CODE_RX_EXC);

endmodule // service_request_ack_chain

// >>> rtl/svc_chain_defs.svh
// register offsets, field positions, codes and reset values of the service request chain
`ifndef SVC_CHAIN_DEFS_SVH
`define SVC_CHAIN_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_SUMMARY 8'h00
`define OFS_RX_CTX 8'h04
`define OFS_TX_CTX 8'h08
`define OFS_LC_CTX 8'h0C
`define OFS_CAR 8'h10
`define OFS_EOS 8'h14
`define OFS_LOCAL_VECTOR_BASE 8'h18
`define OFS_RX_VEC 8'h1C
`define OFS_TX_VEC 8'h20
`define OFS_LC_VEC 8'h24
`define OFS_RX_IND 8'h28
`define OFS_TX_IND 8'h2C
`define OFS_LC_IND 8'h30

// ****************************************************************
// request context register fields
// ****************************************************************
`define CTX_ACTIVE_BIT 7
`define CTX_SERVICE_BIT 6
`define CTX_FAIR_BIT 5
`define CTX_CODE_RX 3'h4
`define CTX_CODE_TX 3'h5
`define CTX_CODE_LC 3'h6

// ****************************************************************
// vector type codes and reset values
// ****************************************************************
`define VEC_CODE_LC 3'h1
`define VEC_CODE_TX 3'h2
`define VEC_CODE_RX_GOOD 3'h3
`define VEC_CODE_RX_EXC 3'h7
`define LOCAL_VECTOR_BASE_RESET 8'h00
`define BYTE_ZERO 8'h00
`define WORD_ZERO 32'h0000_0000

`endif

// >>> rtl/svc_chain_pkg.sv
// types shared by the service request chain
package svc_chain_pkg;

    typedef enum logic [1:0] {SVC_IDLE, SVC_HW, SVC_POLL} svc_mode_t;

    // request from the channel scanner: one per type
    typedef struct packed {
        logic valid;
        logic [1:0] channel;
        logic exception;
    } chan_req_t;

    // current service context seen by the channel datapath
    typedef struct packed {
        logic active;
        logic hw;
        logic [1:0] kind;
        logic [1:0] channel;
    } svc_t;

    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [6:0] sync3;
        logic [6:0] filt;
        logic [2:0] posted;
        logic [2:0] fair;
        logic [2:0][7:0] ctx;
        logic [2:0][7:0] vec;
        logic [7:0] local_vector_base;
        svc_mode_t mode;
        logic [1:0] cur;
        logic claimed;
        logic pass_n;
        logic [31:0] rdata;
        logic err;
    } ctrl_state_t;

endpackage

// >>> dv/host_ack_model.sv
// host side model: acknowledge strobes, first chain grant and abort sensing
`timescale 1ns/1ps

module host_ack_model (
    input wire logic pclk,
    input wire logic [7:0] data_bus,
    input wire logic data_oe,
    input wire logic pass_n,
    output logic [2:0] ack_n,
    output logic grant_n
);
    // ****
    // acknowledge read cycle
    // ****
    assign grant_n = &ack_n;
    initial ack_n = 3'b111;

    // an unclaimed cycle would hang, so chain end or a limit aborts it
    task automatic ack(input int kind, output logic [7:0] vec, output logic claimed,
                       output logic aborted);
        int n;
        claimed = 1'b0;
        aborted = 1'b0;
        vec = 8'h00;
        @(posedge pclk);
        ack_n[kind] <= 1'b0;
        for (n = 0; n < 40; n++) begin
            @(posedge pclk);
            if (data_oe === 1'b1) begin
                claimed = 1'b1;
                vec = data_bus;
                break;
            end
            if (pass_n === 1'b0) begin
                aborted = 1'b1;
                break;
            end
        end
        ack_n <= 3'b111;
    endtask
endmodule // host_ack_model

// >>> dv/service_request_ack_chain_tb.sv
// self-checking bench for the service request and acknowledge block
`timescale 1ns/1ps
`include "svc_chain_defs.svh"

`define CHK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("mismatch %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module service_request_ack_chain_tb
    import svc_chain_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    chan_req_t [2:0] chan_req;
    svc_t svc;
    wire [2:0] req_out;
    wire [2:0] req_oe;
    wire [2:0] ack_n;
    wire grant_n;
    logic chain_pass_out_n;
    logic [7:0] ack_data_out;
    logic ack_data_oe;
    // wired request lines with pull-up
    wire [2:0] req_wire = ~req_oe | req_out;
    wire [5:0] watch = {ack_data_oe, chain_pass_out_n, svc.active, req_oe};
    int mismatches;
    int samples_checked;
    int t;
    logic [31:0] q;
    logic err;
    logic [7:0] vec;
    logic claimed;
    logic aborted;
    logic [1:0] ch;
    logic [2:0] vcode [3];

    service_request_ack_chain service_request_ack_chain_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chan_req(chan_req), .svc(svc),
        .rx_request_n_in(req_wire[0]), .rx_request_n_out(req_out[0]),
        .rx_request_n_oe(req_oe[0]), .tx_request_n_in(req_wire[1]),
        .tx_request_n_out(req_out[1]), .tx_request_n_oe(req_oe[1]),
        .line_change_request_n_in(req_wire[2]), .line_change_request_n_out(req_out[2]),
        .line_change_request_n_oe(req_oe[2]), .rx_acknowledge_n(ack_n[0]),
        .tx_acknowledge_n(ack_n[1]), .line_change_acknowledge_n(ack_n[2]),
        .chain_grant_in_n(grant_n), .chain_pass_out_n(chain_pass_out_n),
        .ack_data_out(ack_data_out), .ack_data_oe(ack_data_oe));

    host_ack_model host_ack_model_inst (
        .pclk(pclk), .data_bus(ack_data_out), .data_oe(ack_data_oe),
        .pass_n(chain_pass_out_n), .ack_n(ack_n), .grant_n(grant_n));

    // ****
    // tasks
    // ****
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            mismatches++;
            close_out();
        end
    endtask

    // bounded wait on one watched output
    task automatic wait_sig(input int sel, input logic v);
        int n;
        for (n = 0; n < 60; n++) begin
            @(posedge pclk);
            if (watch[sel] === v) break;
        end
        if (n == 60) begin
            mismatches++;
            $display("mismatch wait %0d expected %0b seen %0b", sel, v, watch[sel]);
            close_out();
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ****
    // sequence
    // ****
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        chan_req = '0;
        mismatches = 0;
        samples_checked = 0;
        vcode = '{`VEC_CODE_RX_GOOD, `VEC_CODE_TX, `VEC_CODE_LC};
        repeat (6) @(posedge pclk);
        `CHK("reset pass", 1'b1, chain_pass_out_n)
        `CHK("reset oe", 3'b000, req_oe)
        presetn <= 1'b1;
        apb(1'b1, `OFS_SUMMARY, 32'hFF, q, err);
        apb(1'b0, `OFS_SUMMARY, 32'h0, q, err);
        `CHK("summary idle", 32'h0, q)
        apb(1'b1, `OFS_LOCAL_VECTOR_BASE, 32'hAD, q, err);
        apb(1'b0, `OFS_LOCAL_VECTOR_BASE, 32'h0, q, err);
        `CHK("base", 32'hA8, q)
        apb(1'b0, 8'h3C, 32'h0, q, err);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, q)
        $display("test registers done");
        for (t = 0; t < 3; t++) begin
            ch = 2'(3 - t);
            chan_req[t] <= {1'b1, ch, 1'b0};
            wait_sig(t, 1'b1);
            `CHK("wired line", 1'b0, req_wire[t])
            chan_req[t] <= '0;
            apb(1'b0, `OFS_SUMMARY, 32'h0, q, err);
            `CHK("summary", 32'(1 << t), q)
            apb(1'b0, `OFS_RX_CTX + 8'(4 * t), 32'h0, q, err);
            `CHK("context", {24'h0, 3'b100, 3'(`CTX_CODE_RX + t), ch}, q)
            apb(1'b0, `OFS_RX_VEC + 8'(4 * t), 32'h0, q, err);
            `CHK("vector reg", {24'h0, 5'h15, vcode[t]}, q)
            host_ack_model_inst.ack(t, vec, claimed, aborted);
            `CHK("claimed", 1'b1, claimed)
            `CHK("not passed", 1'b0, aborted)
            `CHK("ack vector", {5'h15, vcode[t]}, vec)
            `CHK("hw ctx", {2'b11, 2'(t), ch}, {svc.active, svc.hw, svc.kind, svc.channel})
            `CHK("released", 1'b0, req_oe[t])
            apb(1'b0, `OFS_RX_IND + 8'(4 * t), 32'h0, q, err);
            `CHK("indicator", {30'h0, ch}, q)
            wait_sig(5, 1'b0);
            apb(1'b1, `OFS_EOS, 32'h5A, q, err);
            wait_sig(3, 1'b0);
        end
        $display("test hardware acknowledge done");
        chan_req[0] <= {1'b1, 2'd1, 1'b1};
        wait_sig(0, 1'b1);
        chan_req[0] <= '0;
        apb(1'b0, `OFS_SUMMARY, 32'h0, q, err);
        `CHK("poll summary", 32'h1, q)
        apb(1'b0, `OFS_RX_VEC, 32'h0, q, err);
        `CHK("exc vector", {24'h0, 5'h15, `VEC_CODE_RX_EXC}, q)
        apb(1'b0, `OFS_RX_CTX, 32'h0, q, err);
        `CHK("poll ctx", {24'h0, 3'b100, `CTX_CODE_RX, 2'd1}, q)
        apb(1'b1, `OFS_CAR, q, q, err);
        wait_sig(3, 1'b1);
        `CHK("poll svc", 5'b00001, {svc.hw, svc.kind, svc.channel})
        `CHK("poll released", 1'b0, req_oe[0])
        apb(1'b1, `OFS_RX_CTX, {24'h0, 3'b000, `CTX_CODE_RX, 2'd1}, q, err);
        wait_sig(3, 1'b0);
        $display("test poll done");
        host_ack_model_inst.ack(1, vec, claimed, aborted);
        `CHK("unclaimed", 1'b0, claimed)
        `CHK("chain end", 1'b1, aborted)
        `CHK("no drive", 1'b0, ack_data_oe)
        wait_sig(4, 1'b1);
        `CHK("still idle", 1'b0, svc.active)
        $display("test chain pass done");
        close_out();
    end
endmodule // service_request_ack_chain_tb
